// ### src/sbpcs_pkg.sv
// Package of constants and carrier types for the sideband package/channel state block
package sbpcs_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int          NUM_CH        = 2;
  localparam int          CHID_W        = 5;
  localparam int          PKGID_W       = 3;
  localparam int          ICHID_W       = 2;
  localparam int          CLK_PERIOD_NS = 8;
  // Power-up to Initial State bound, in microseconds (shortened by parameter)
  localparam int          INIT_TIME_US  = 100;
  localparam int          INIT_CYCLES   = (INIT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int          NOTRDY_CYCLES = 4;
  localparam int          TMR_W         = 24;

  // ****************************************************************
  // Channel id layout and reset values
  // ****************************************************************
  localparam int          ICHID_LSB     = 0;
  localparam int          PKGID_LSB     = 2;
  localparam logic [1:0]  ICHID_PKG     = 2'h3;   // Internal id addressing the package
  localparam logic        RST_ARB_EN    = 1'h1;

  // Package interface state, one-hot
  typedef enum logic [3:0] {
    SBPCS_PWRDN  = 4'h1,
    SBPCS_PWRUP  = 4'h2,
    SBPCS_NOTRDY = 4'h4,
    SBPCS_READY  = 4'h8
  } sbpcs_pkg_state_e;

  // Channel state, one-hot
  typedef enum logic [3:0] {
    SBPCS_CH_NOTRDY = 4'h1,
    SBPCS_CH_INIT   = 4'h2,
    SBPCS_CH_DIS    = 4'h4,
    SBPCS_CH_EN     = 4'h8
  } sbpcs_ch_state_e;

  // Decoded command strobe from the sideband receiver
  typedef struct packed {
    logic                valid;
    logic [CHID_W-1:0]   chId;
    logic                select;
    logic                deselect;
    logic                enable;
    logic                disable_;
    logic                resetCh;
    logic                clearInit;
  } sbpcs_cmd_s;

  // Per-channel transmit requests
  typedef struct packed {
    logic                rsp;
    logic                aen;
    logic                pass;
  } sbpcs_txreq_s;

endpackage : sbpcs_pkg

// ### src/sbpcs_channel.sv
// One channel's Ready / Initial / enable state
`timescale 1ns/1ns
module sbpcs_channel (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          powerUp,
  input  wire logic                          pkgReady,
  input  wire logic                          asyncLoss,
  input  wire logic [sbpcs_pkg::ICHID_W-1:0] chIndex,
  input  wire logic [sbpcs_pkg::PKGID_W-1:0] pkgId,
  input  wire sbpcs_pkg::sbpcs_cmd_s         cmd,
  output logic                               chAccept,
  output logic                               initState,
  output logic                               chEnabled,
  output sbpcs_pkg::sbpcs_ch_state_e         chState
);
  import sbpcs_pkg::*;

  logic            hit;
  logic            wasUp;
  logic [2:0]      nrCnt;
  sbpcs_ch_state_e next_chState;

  // Channel id match: package id joined with internal channel id
  assign hit = cmd.valid && (cmd.chId == {pkgId, chIndex});

  // Accepted only outside Not Ready
  assign chAccept = hit && (chState != SBPCS_CH_NOTRDY);
  assign initState = (chState == SBPCS_CH_INIT);
  assign chEnabled = (chState == SBPCS_CH_EN);

  // Next channel state
  always_comb begin
    next_chState = chState;
    case (chState)
      SBPCS_CH_NOTRDY: begin
        if (powerUp && pkgReady && nrCnt == 3'(NOTRDY_CYCLES - 1)) begin
          next_chState = SBPCS_CH_INIT;
        end
      end
      SBPCS_CH_INIT: begin
        if (chAccept && cmd.clearInit) begin
          next_chState = SBPCS_CH_DIS;
        end
      end
      SBPCS_CH_DIS: begin
        if (chAccept && cmd.enable) begin
          next_chState = SBPCS_CH_EN;
        end
      end
      SBPCS_CH_EN: begin
        if (chAccept && cmd.disable_) begin
          next_chState = SBPCS_CH_DIS;
        end
      end
      default: next_chState = SBPCS_CH_NOTRDY;
    endcase
    if (chState != SBPCS_CH_NOTRDY && (asyncLoss || (chAccept && cmd.resetCh))) begin
      next_chState = SBPCS_CH_INIT;
    end
    if (!powerUp) begin
      next_chState = SBPCS_CH_NOTRDY;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      chState <= SBPCS_CH_NOTRDY;
    end else begin
      chState <= next_chState;
    end
  end

  // Not Ready dwell counter
  always_ff @(posedge clk) begin
    if (srst || chState != SBPCS_CH_NOTRDY || !pkgReady) begin
      nrCnt <= 3'h0;
    end else if (nrCnt != 3'(NOTRDY_CYCLES - 1)) begin
      nrCnt <= nrCnt + 3'h1;
    end
  end

  // Helper: previous power state for assertions
  always_ff @(posedge clk) begin
    if (srst) begin
      wasUp <= 1'h0;
    end else begin
      wasUp <= powerUp;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  reset_to_init_a: assert property (@(posedge clk) disable iff (srst)
    (chAccept && cmd.resetCh && powerUp) |=> (chState == SBPCS_CH_INIT))
    else $error("reset channel did not reach Initial State");

  init_disabled_a: assert property (@(posedge clk) disable iff (srst)
    (chState == SBPCS_CH_INIT) |=> (chState != SBPCS_CH_EN))
    else $error("channel left Initial State straight to enabled");

  notrdy_refuse_a: assert property (@(posedge clk) disable iff (srst)
    (chState == SBPCS_CH_NOTRDY) |-> !chAccept)
    else $error("Not Ready channel accepted a command");

  // After a cycle without power the channel starts again from Not Ready
  power_down_a: assert property (@(posedge clk) disable iff (srst)
    !wasUp |-> (chState == SBPCS_CH_NOTRDY))
    else $error("channel left Not Ready without power");

endmodule : sbpcs_channel

// ### src/sbpcs_top.sv
// Package and channel operating state tracker for a shared sideband interface
`timescale 1ns/1ns
// Overview of operation
// - Selected package may drive buffers and transmit, subject to arbitration.
// - Deselected package keeps buffers off and never transmits.
// - With arbitration on, transmit needs selection and the token.
// - With arbitration off, selection alone allows transmit.
// - Package Ready accepts package commands and can become Selected.
// - Package Not Ready refuses package commands.
// - Channel Ready accepts commands matching package plus internal channel id.
// - Channel Not Ready refuses channel commands.
// - Initial State accepts commands and flags that configuration is needed.
// - Enabled channel may send events and pass-through while package Selected.
// - Disabled channel sends no events or pass-through traffic.
// - Output buffers stay off during interface power-up.
// - Link change on an enabled channel raises an event; a disabled channel's events are cleared.
// - Entering Initial State leaves the channel disabled.
// - Reset channel command returns the channel to Initial State.
module sbpcs_top #(
  parameter int INIT_LIMIT = sbpcs_pkg::INIT_CYCLES
) (
  input  wire logic                                clk,
  input  wire logic                                srst,
  input  wire logic                                powerUp,
  input  wire logic [sbpcs_pkg::PKGID_W-1:0]       pkgId,
  input  wire logic                                arbToken,
  input  wire logic                                arbEnSet,
  input  wire logic                                arbEnClr,
  input  wire sbpcs_pkg::sbpcs_cmd_s               cmd,
  input  wire logic [sbpcs_pkg::NUM_CH-1:0]        linkUp,
  input  wire logic [sbpcs_pkg::NUM_CH-1:0]        asyncLoss,
  input  wire sbpcs_pkg::sbpcs_txreq_s [1:0]       txReq,
  input  wire logic [sbpcs_pkg::NUM_CH-1:0]        aenAck,
  output logic                                     pkgAccept,
  output logic [sbpcs_pkg::NUM_CH-1:0]             chAccept,
  output logic                                     selected,
  output logic                                     arbEnabled,
  output logic                                     txOe,
  output logic                                     txAllowed,
  output logic [sbpcs_pkg::NUM_CH-1:0]             txGrant,
  output logic [sbpcs_pkg::NUM_CH-1:0]             initState,
  output logic [sbpcs_pkg::NUM_CH-1:0]             chEnabled,
  output logic [sbpcs_pkg::NUM_CH-1:0]             aenPending,
  output logic                                     initTimeout,
  output sbpcs_pkg::sbpcs_pkg_state_e              pkgState
);
  import sbpcs_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sbpcs_pkg_state_e              next_pkgState;
  sbpcs_ch_state_e [NUM_CH-1:0]  chState;
  logic                          pkgHit;
  logic                          permit;
  logic [TMR_W-1:0]              initTmr;
  logic [NUM_CH-1:0]             linkPrev;
  logic [NUM_CH-1:0]             unreqOk;
  logic                          wasPwr;
  logic                          arbSeen;

  // ****************************************************************
  // Package state
  // ****************************************************************

  // Package-directed command decode
  assign pkgHit = cmd.valid && (cmd.chId == {pkgId, ICHID_PKG});
  assign pkgAccept = pkgHit && (pkgState == SBPCS_READY);

  // Next package state
  always_comb begin
    next_pkgState = pkgState;
    case (pkgState)
      SBPCS_PWRDN: begin
        if (powerUp) begin
          next_pkgState = SBPCS_PWRUP;
        end
      end
      SBPCS_PWRUP: begin
        next_pkgState = SBPCS_NOTRDY;
      end
      SBPCS_NOTRDY: begin
        next_pkgState = SBPCS_READY;
      end
      SBPCS_READY: begin
        next_pkgState = SBPCS_READY;
      end
      default: next_pkgState = SBPCS_PWRDN;
    endcase
    if (!powerUp) begin
      next_pkgState = SBPCS_PWRDN;
    end
  end

  // Package state register
  always_ff @(posedge clk) begin
    if (srst) begin
      pkgState <= SBPCS_PWRDN;
    end else begin
      pkgState <= next_pkgState;
    end
  end

  // Selection: only a Ready package takes select; only a select command selects it
  always_ff @(posedge clk) begin
    if (srst || pkgState != SBPCS_READY) begin
      selected <= 1'h0;
    end else if (pkgAccept && cmd.deselect) begin
      selected <= 1'h0;
    end else if (pkgAccept && cmd.select) begin
      selected <= 1'h1;
    end
  end

  // Arbitration enable, forced on at reset and at interface power-up
  always_ff @(posedge clk) begin
    if (srst || pkgState == SBPCS_PWRUP) begin
      arbEnabled <= RST_ARB_EN;
    end else if (arbEnClr) begin
      arbEnabled <= 1'h0;
    end else if (arbEnSet) begin
      arbEnabled <= 1'h1;
    end
  end

  // ****************************************************************
  // Transmit permission
  // ****************************************************************

  // Selection plus token when arbitration is on
  assign permit = selected && (pkgState == SBPCS_READY)
                  && (!arbEnabled || arbToken);
  assign txAllowed = permit;

  // Output buffer enable
  always_ff @(posedge clk) begin
    if (srst) begin
      txOe <= 1'h0;
    end else begin
      txOe <= permit;
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  for (genvar i = 0; i < NUM_CH; i++) begin : gCh
    sbpcs_channel uChan (
      .clk       (clk),
      .srst      (srst),
      .powerUp   (powerUp),
      .pkgReady  (pkgState == SBPCS_READY),
      .asyncLoss (asyncLoss[i]),
      .chIndex   (ICHID_W'(i)),
      .pkgId     (pkgId),
      .cmd       (cmd),
      .chAccept  (chAccept[i]),
      .initState (initState[i]),
      .chEnabled (chEnabled[i]),
      .chState   (chState[i])
    );

    // Unrequested traffic only from an enabled channel
    assign unreqOk[i] = chEnabled[i] && (txReq[i].aen || txReq[i].pass);

    // Responses ignore enable; unrequested needs enable
    assign txGrant[i] = permit && (txReq[i].rsp || unreqOk[i]);
  end

  // Link change events, set wins over acknowledge
  always_ff @(posedge clk) begin
    if (srst) begin
      linkPrev   <= '0;
      aenPending <= '0;
    end else begin
      linkPrev   <= linkUp;
      aenPending <= ((aenPending & ~aenAck) | (linkUp ^ linkPrev)) & chEnabled;
    end
  end

  // ****************************************************************
  // Power-up to Initial State watchdog
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst || !powerUp) begin
      initTmr     <= '0;
      initTimeout <= 1'h0;
    end else if (|(chState & {NUM_CH{SBPCS_CH_NOTRDY}}) && !(&initState | |chEnabled)) begin
      if (initTmr == TMR_W'(INIT_LIMIT)) begin
        initTimeout <= 1'h1;
      end else begin
        initTmr <= initTmr + TMR_W'(1);
      end
    end
  end

  // Helpers for assertions
  always_ff @(posedge clk) begin
    if (srst) begin
      wasPwr  <= 1'h0;
      arbSeen <= 1'h0;
    end else begin
      wasPwr  <= powerUp;
      arbSeen <= arbEnabled;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  deselect_quiet_a: assert property (@(posedge clk) disable iff (srst)
    !selected |=> !txOe)
    else $error("buffers on while deselected");

  token_gate_a: assert property (@(posedge clk) disable iff (srst)
    (arbEnabled && !arbToken) |-> (txGrant == '0))
    else $error("transmit granted without token");

  no_arb_send_a: assert property (@(posedge clk) disable iff (srst)
    (!arbEnabled && selected && (pkgState == SBPCS_READY) && txReq[0].rsp)
    |-> txGrant[0])
    else $error("response blocked with arbitration off");

  notready_pkg_a: assert property (@(posedge clk) disable iff (srst)
    (pkgState != SBPCS_READY) |-> !pkgAccept)
    else $error("package command accepted while not ready");

  select_take_a: assert property (@(posedge clk) disable iff (srst)
    (pkgAccept && cmd.select && !cmd.deselect && powerUp) |=> selected)
    else $error("select command not taken");

  powerup_off_a: assert property (@(posedge clk) disable iff (srst)
    (pkgState == SBPCS_PWRUP) |-> ##1 !txOe [*2])
    else $error("buffers enabled during power-up");

  disabled_quiet_a: assert property (@(posedge clk) disable iff (srst)
    (!chEnabled[1] && !txReq[1].rsp) |-> !txGrant[1])
    else $error("disabled channel sent unrequested traffic");

  reach_init_a: assert property (@(posedge clk) disable iff (srst)
    ($rose(pkgState == SBPCS_READY) && powerUp) |-> ##[1:8] (initState[0] || !powerUp))
    else $error("channel missed Initial State");

  init_flag_a: assert property (@(posedge clk) disable iff (srst)
    (initState[0] && cmd.valid && cmd.chId == {pkgId, 2'h0}) |-> chAccept[0])
    else $error("Initial State channel refused command");

  // A fresh power-up turns arbitration on two edges later
  arb_powerup_a: assert property (@(posedge clk) disable iff (srst)
    (!wasPwr && powerUp) |=> ##1 arbEnabled)
    else $error("arbitration not enabled after power-up");

  // Channel resets never disturb the arbitration setting
  arb_kept_a: assert property (@(posedge clk) disable iff (srst)
    ((pkgState == SBPCS_READY) && !arbEnSet && !arbEnClr) |=> (arbEnabled == arbSeen))
    else $error("arbitration setting changed without a command");

endmodule : sbpcs_top

// ### dv/sbpcs_mc_model.sv
// Management controller model driving decoded commands into the block
`timescale 1ns/1ns
module sbpcs_mc_model (
  input  wire logic                        clk,
  input  wire logic                        pkgAccept,
  input  wire logic [sbpcs_pkg::NUM_CH-1:0] chAccept,
  output sbpcs_pkg::sbpcs_cmd_s            cmd
);
  import sbpcs_pkg::*;
  // ****
  // Command driver
  // ****
  logic              lastPkgAcc;
  logic [NUM_CH-1:0] lastChAcc;

  // Idle bus at time zero
  initial begin
    cmd        = '0;
    lastPkgAcc = 1'b0;
    lastChAcc  = '0;
  end

  // Holds a command level until changed
  task automatic drive(input sbpcs_cmd_s c);
    @(posedge clk);
    cmd <= c;
  endtask : drive

  // One command cycle; a command left unanswered is sent again
  task automatic send(input sbpcs_cmd_s c, input int tries);
    for (int i = 0; i < tries; i++) begin
      @(posedge clk);
      cmd <= c;
      #1;
      lastPkgAcc = pkgAccept;
      lastChAcc  = chAccept;
      @(posedge clk);
      cmd <= '0;
      if (lastPkgAcc === 1'b1 || lastChAcc !== '0) break;
    end
  endtask : send
endmodule : sbpcs_mc_model

// ### dv/tb.sv
// Self-checking bench for the sideband package and channel state tracker
`timescale 1ns/1ns
module tb;
  import sbpcs_pkg::*;
  // ****
  // Bench signals
  // ****
  localparam int         LIM = 50;
  localparam logic [2:0] PID = 3'h5;
  typedef struct packed {
    logic [4:0] id;
    logic [5:0] fl;
    logic       pAcc;
    logic [1:0] cAcc;
    logic       sel;
    logic [1:0] en;
    logic [1:0] init;
  } sbpcs_row_s;
  logic clk, srst, powerUp, arbToken, arbEnSet, arbEnClr;
  logic [2:0] pkgId;
  logic [1:0] linkUp, asyncLoss, aenAck, chAccept, txGrant, initState, chEnabled, aenPending;
  logic pkgAccept, selected, arbEnabled, txOe, txAllowed, initTimeout;
  sbpcs_txreq_s [1:0] txReq;
  sbpcs_cmd_s         cmd;
  sbpcs_pkg_state_e   pkgState;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int cnt;
  // Flags: select deselect enable disable reset clear-initial
  sbpcs_row_s rows [9] = '{
    '{5'h14, 6'h01, 1'b0, 2'h1, 1'b0, 2'h0, 2'h2},
    '{5'h15, 6'h01, 1'b0, 2'h2, 1'b0, 2'h0, 2'h0},
    '{5'h10, 6'h08, 1'b0, 2'h0, 1'b0, 2'h0, 2'h0},
    '{5'h17, 6'h20, 1'b1, 2'h0, 1'b1, 2'h0, 2'h0},
    '{5'h14, 6'h08, 1'b0, 2'h1, 1'b1, 2'h1, 2'h0},
    '{5'h17, 6'h30, 1'b1, 2'h0, 1'b0, 2'h1, 2'h0},
    '{5'h17, 6'h20, 1'b1, 2'h0, 1'b1, 2'h1, 2'h0},
    '{5'h14, 6'h04, 1'b0, 2'h1, 1'b1, 2'h0, 2'h0},
    '{5'h14, 6'h08, 1'b0, 2'h1, 1'b1, 2'h1, 2'h0}};

  sbpcs_top #(.INIT_LIMIT(LIM)) i_sbpcs_top (.clk(clk), .srst(srst), .powerUp(powerUp),
    .pkgId(pkgId), .arbToken(arbToken), .arbEnSet(arbEnSet), .arbEnClr(arbEnClr), .cmd(cmd),
    .linkUp(linkUp), .asyncLoss(asyncLoss), .txReq(txReq), .aenAck(aenAck),
    .pkgAccept(pkgAccept), .chAccept(chAccept), .selected(selected), .arbEnabled(arbEnabled),
    .txOe(txOe), .txAllowed(txAllowed), .txGrant(txGrant), .initState(initState),
    .chEnabled(chEnabled), .aenPending(aenPending), .initTimeout(initTimeout),
    .pkgState(pkgState));
  sbpcs_mc_model i_sbpcs_mc_model (.clk(clk), .pkgAccept(pkgAccept), .chAccept(chAccept),
    .cmd(cmd));

  // ****
  // Helpers
  // ****
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic sbpcs_cmd_s mk(input logic [4:0] id, input logic [5:0] fl);
    return sbpcs_cmd_s'({1'b1, id, fl});
  endfunction : mk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic req(input logic [5:0] v);
    @(posedge clk) txReq <= v;
    #1;
  endtask : req

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ****
  // Tests
  // ****
  initial begin
    srst = 1'b1; powerUp = 1'b0; pkgId = PID; arbToken = 1'b0; arbEnSet = 1'b0;
    arbEnClr = 1'b0; linkUp = '0; asyncLoss = '0; txReq = '0; aenAck = '0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    step(1);
    chk("pkgState", pkgState, SBPCS_PWRDN);
    chk("arbEnabled", arbEnabled, 1'b1);
    chk("txOe", txOe, 1'b0);
    // Power up with a package command held
    i_sbpcs_mc_model.drive(mk({PID, 2'h3}, 6'h00));
    @(posedge clk) powerUp <= 1'b1;
    cnt = 0;
    step(1);
    while (pkgState !== SBPCS_READY && cnt < 20) begin
      chk("pkgAccept", pkgAccept, 1'b0);
      chk("txOe", txOe, 1'b0);
      cnt++;
      step(1);
    end
    chk("pkgAccept", pkgAccept, 1'b1);
    i_sbpcs_mc_model.drive('0);
    while (initState !== 2'h3 && cnt < LIM + 20) begin
      step(1);
      cnt++;
    end
    chk("initTime", cnt <= LIM, 1'b1);
    chk("initTimeout", initTimeout, 1'b0);
    $display("test powerup done");
    foreach (rows[i]) begin
      i_sbpcs_mc_model.send(mk(rows[i].id, rows[i].fl), 2);
      #1;
      chk("pkgAccept", i_sbpcs_mc_model.lastPkgAcc, rows[i].pAcc);
      chk("chAccept", i_sbpcs_mc_model.lastChAcc, rows[i].cAcc);
      chk("selected", selected, rows[i].sel);
      chk("chEnabled", chEnabled, rows[i].en);
      chk("initState", initState, rows[i].init);
    end
    $display("test table done");
    step(1);
    chk("txAllowed", txAllowed, 1'b0);
    chk("txOe", txOe, 1'b0);
    @(posedge clk) arbToken <= 1'b1;
    #1 chk("txAllowed", txAllowed, 1'b1);
    step(1);
    chk("txOe", txOe, 1'b1);
    @(posedge clk) begin
      arbToken <= 1'b0;
      arbEnClr <= 1'b1;
    end
    @(posedge clk) arbEnClr <= 1'b0;
    #1 chk("arbEnabled", arbEnabled, 1'b0);
    chk("txAllowed", txAllowed, 1'b1);
    @(posedge clk) arbEnSet <= 1'b1;
    @(posedge clk) arbEnSet <= 1'b0;
    #1 chk("arbEnabled", arbEnabled, 1'b1);
    chk("txAllowed", txAllowed, 1'b0);
    @(posedge clk) arbToken <= 1'b1;
    req(6'h01);
    chk("txGrant", txGrant, 2'h1);
    req(6'h08);
    chk("txGrant", txGrant, 2'h0);
    req(6'h20);
    chk("txGrant", txGrant, 2'h2);
    @(posedge clk) arbToken <= 1'b0;
    #1 chk("txGrant", txGrant, 2'h0);
    req(6'h00);
    $display("test transmit done");
    @(posedge clk) linkUp <= 2'h3;
    for (cnt = 0; cnt < 8 && aenPending[0] !== 1'b1; cnt++) step(1);
    chk("aenPending", aenPending, 2'h1);
    @(posedge clk) aenAck <= 2'h1;
    @(posedge clk) aenAck <= 2'h0;
    #1 chk("aenPending", aenPending, 2'h0);
    // Link change and acknowledge in one cycle: the new event must stay
    @(posedge clk) begin
      linkUp <= 2'h2;
      aenAck <= 2'h1;
    end
    @(posedge clk) aenAck <= 2'h0;
    #1 chk("aenPending", aenPending, 2'h1);
    $display("test event done");
    @(posedge clk) arbToken <= 1'b1;
    i_sbpcs_mc_model.send(mk({PID, 2'h3}, 6'h10), 2);
    step(1);
    chk("selected", selected, 1'b0);
    chk("txAllowed", txAllowed, 1'b0);
    chk("txOe", txOe, 1'b0);
    i_sbpcs_mc_model.send(mk({PID, 2'h0}, 6'h02), 2);
    #1;
    for (cnt = 0; cnt < 8 && initState !== 2'h1; cnt++) step(1);
    chk("initState", initState, 2'h1);
    chk("chEnabled", chEnabled, 2'h0);
    @(posedge clk) asyncLoss <= 2'h2;
    @(posedge clk) asyncLoss <= 2'h0;
    #1;
    for (cnt = 0; cnt < 8 && initState !== 2'h3; cnt++) step(1);
    chk("initState", initState, 2'h3);
    $display("test reset done");
    @(posedge clk) powerUp <= 1'b0;
    step(2);
    chk("pkgState", pkgState, SBPCS_PWRDN);
    chk("txOe", txOe, 1'b0);
    i_sbpcs_mc_model.drive(mk({PID, 2'h0}, 6'h00));
    @(posedge clk) powerUp <= 1'b1;
    step(1);
    for (cnt = 0; cnt < 20 && initState[0] !== 1'b1; cnt++) begin
      chk("chAccept", chAccept[0], 1'b0);
      step(1);
    end
    chk("chAccept", chAccept[0], 1'b1);
    i_sbpcs_mc_model.drive('0);
    $display("test repower done");
    step(2);
    give_verdict();
  end
endmodule : tb
